// *** verilog/rrh_pkg.sv ***
// constants for the slave read frame handler
// Notes on behaviour
// - addresses, counts, values are 16-bit, high first
// - no frame longer than 128 bytes
// - bit reply: address, function, count, data, CRC
// - first bit in bit 0, eight per byte
// - unused upper bits of last byte are zero
// - register reply: count, registers ascending, high first
// - reply repeats received address and function code
// - answer only own node number 1 to 247
// - never reply to broadcast reads
// - registers zero offset, variables from 5000
// - status bits at 0, command bits at 100
`default_nettype none
package rrh_pkg;
    // -----------------------------------------------------------------
    // frame layout
    // -----------------------------------------------------------------
    localparam logic [7:0]  FN_READ_BITS  = 8'h01;
    localparam logic [7:0]  FN_READ_REGS  = 8'h03;
    localparam logic [7:0]  ADDR_BCAST    = 8'h00;
    localparam logic [7:0]  NODE_MIN      = 8'h01;
    localparam logic [7:0]  NODE_MAX      = 8'hf7;
    localparam logic [3:0]  QUERY_LEN     = 4'h8;
    localparam logic [7:0]  FRAME_MAX     = 8'h80;
    localparam logic [15:0] BITS_MAX      = 16'h03d8;
    localparam logic [15:0] REGS_MAX      = 16'h003d;
    localparam int          BITS_PER_BYTE = 8;
    // -----------------------------------------------------------------
    // address map
    // -----------------------------------------------------------------
    localparam logic [15:0] STATUS_BASE   = 16'h0000;
    localparam logic [15:0] CMD_BASE      = 16'h0064;
    localparam logic [15:0] PARAM_BASE    = 16'h0000;
    localparam logic [15:0] VAR_BASE      = 16'h1388;
    localparam logic [15:0] GROUP_BITS    = 16'h0008;
    // -----------------------------------------------------------------
    // crc
    // -----------------------------------------------------------------
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CRC_POLY      = 16'ha001;
    localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0000,
        S_ADDR  = 4'b0001,
        S_FUNC  = 4'b0010,
        S_CNT   = 4'b0011,
        S_COIL  = 4'b0100,
        S_FETCH = 4'b0101,
        S_REGHI = 4'b0110,
        S_REGLO = 4'b0111,
        S_CRCLO = 4'b1000,
        S_CRCHI = 4'b1001
    } rrh_state_type;

    function automatic logic [15:0] rrh_crc_step(input logic [15:0] c,
                                                 input logic [7:0]  b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : rrh_crc_step
endpackage : rrh_pkg
`default_nettype wire

// *** verilog/rrh_frame_handler.sv ***
// slave frame handler for the bit read and register read services
`default_nettype none
`timescale 1ns/1ps
module rrh_frame_handler
    import rrh_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  node_addr_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_end_i,
    input  wire logic [7:0]  status_bits_i,
    input  wire logic [7:0]  cmd_bits_i,
    output logic             reg_req_o,
    output logic [15:0]      reg_addr_o,
    input  wire logic        reg_ack_i,
    input  wire logic [15:0] reg_data_i,
    output logic             tx_valid_o,
    output logic [7:0]       tx_data_o,
    output logic             tx_last_o,
    input  wire logic        tx_ready_i,
    output logic             busy_o
);
    // -----------------------------------------------------------------
    // query receiver
    // -----------------------------------------------------------------
    logic [7:0]    q_byte_q [QUERY_LEN];
    logic [3:0]    rx_idx_q;
    logic [15:0]   rx_crc_q;
    rrh_state_type st_q;
    logic          start;
    logic [15:0]   q_cnt;
    logic          node_ok;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_idx_q <= 4'h0;
            rx_crc_q <= CRC_INIT;
            for (int i = 0; i < QUERY_LEN; i++) q_byte_q[i] <= 8'h00;
        end else if (rx_end_i) begin
            rx_idx_q <= 4'h0;
            rx_crc_q <= CRC_INIT;
        end else if (rx_valid_i) begin
            if (rx_idx_q < QUERY_LEN) q_byte_q[rx_idx_q[2:0]] <= rx_data_i;
            if (rx_idx_q <= QUERY_LEN) rx_idx_q <= rx_idx_q + 4'h1;
            rx_crc_q <= rrh_crc_step(rx_crc_q, rx_data_i);
        end
    end

    assign q_cnt   = {q_byte_q[4], q_byte_q[5]};
    assign node_ok = (node_addr_i >= NODE_MIN) && (node_addr_i <= NODE_MAX);
    // broadcast never matches a legal node number
    assign start = rx_end_i && (st_q == S_IDLE) && (rx_idx_q == QUERY_LEN)
                && (rx_crc_q == CRC_RESIDUE) && node_ok
                && (q_byte_q[0] == node_addr_i) && (q_cnt != 16'h0000)
                && (((q_byte_q[1] == FN_READ_BITS) && (q_cnt <= BITS_MAX))
                 || ((q_byte_q[1] == FN_READ_REGS) && (q_cnt <= REGS_MAX)));

    // -----------------------------------------------------------------
    // response sequencer
    // -----------------------------------------------------------------
    logic [7:0]  node_q;
    logic [7:0]  func_q;
    logic [7:0]  bc_q;
    logic [7:0]  bc_left_q;
    logic [15:0] cur_addr_q;
    logic [15:0] left_q;
    logic [15:0] reg_val_q;
    logic [15:0] tx_crc_q;
    logic [7:0]  tx_cnt_q;
    logic [7:0]  push_data;
    logic        push_valid;
    logic        push_last;
    logic        push_ready;
    logic        fire;
    logic [7:0]  coil_byte;

    function automatic logic coil_bit(input logic [15:0] a);
        logic [15:0] off;
        off = a - CMD_BASE;
        if (a - STATUS_BASE < GROUP_BITS) return status_bits_i[a[2:0]];
        if (off < GROUP_BITS) return cmd_bits_i[off[2:0]];
        return 1'b0;
    endfunction : coil_bit

    always_comb begin
        coil_byte = 8'h00;
        for (int j = 0; j < BITS_PER_BYTE; j++) begin
            // first bit to bit 0, bits past the count stay zero
            if (16'(j) < left_q) coil_byte[j] = coil_bit(cur_addr_q + 16'(j));
        end
    end

    always_comb begin
        push_valid = 1'b1;
        push_data  = 8'h00;
        case (st_q)
            S_ADDR:  push_data = node_q;
            S_FUNC:  push_data = func_q;
            S_CNT:   push_data = bc_q;
            S_COIL:  push_data = coil_byte;
            S_REGHI: push_data = reg_val_q[15:8];
            S_REGLO: push_data = reg_val_q[7:0];
            S_CRCLO: push_data = tx_crc_q[7:0];
            S_CRCHI: push_data = tx_crc_q[15:8];
            default: push_valid = 1'b0;
        endcase
    end

    assign push_last = (st_q == S_CRCHI);
    assign fire      = push_valid && push_ready;
    assign busy_o    = (st_q != S_IDLE);
    assign reg_req_o = (st_q == S_FETCH);
    assign reg_addr_o = cur_addr_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q       <= S_IDLE;
            node_q     <= 8'h00;
            func_q     <= 8'h00;
            bc_q       <= 8'h00;
            bc_left_q  <= 8'h00;
            cur_addr_q <= 16'h0000;
            left_q     <= 16'h0000;
            reg_val_q  <= 16'h0000;
        end else begin
            case (st_q)
                S_IDLE: if (start) begin
                    st_q       <= S_ADDR;
                    node_q     <= q_byte_q[0];
                    func_q     <= q_byte_q[1];
                    cur_addr_q <= {q_byte_q[2], q_byte_q[3]};
                    left_q     <= q_cnt;
                    if (q_byte_q[1] == FN_READ_BITS) begin
                        bc_q      <= 8'((17'(q_cnt) + 17'd7) >> 3);
                        bc_left_q <= 8'((17'(q_cnt) + 17'd7) >> 3);
                    end else begin
                        bc_q      <= {q_cnt[6:0], 1'b0};
                        bc_left_q <= {q_cnt[6:0], 1'b0};
                    end
                end
                S_ADDR: if (fire) st_q <= S_FUNC;
                S_FUNC: if (fire) st_q <= S_CNT;
                S_CNT: if (fire) begin
                    st_q <= (func_q == FN_READ_BITS) ? S_COIL : S_FETCH;
                end
                S_COIL: if (fire) begin
                    bc_left_q  <= bc_left_q - 8'h01;
                    cur_addr_q <= cur_addr_q + GROUP_BITS;
                    left_q     <= (left_q > GROUP_BITS) ?
                                  left_q - GROUP_BITS : 16'h0000;
                    if (bc_left_q == 8'h01) st_q <= S_CRCLO;
                end
                S_FETCH: if (reg_ack_i) begin
                    reg_val_q <= reg_data_i;
                    st_q      <= S_REGHI;
                end
                S_REGHI: if (fire) st_q <= S_REGLO;
                S_REGLO: if (fire) begin
                    cur_addr_q <= cur_addr_q + 16'h0001;
                    left_q     <= left_q - 16'h0001;
                    st_q <= (left_q == 16'h0001) ? S_CRCLO : S_FETCH;
                end
                S_CRCLO: if (fire) st_q <= S_CRCHI;
                S_CRCHI: if (fire) st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_crc_q <= CRC_INIT;
            tx_cnt_q <= 8'h00;
        end else if (st_q == S_IDLE) begin
            tx_crc_q <= CRC_INIT;
            tx_cnt_q <= 8'h00;
        end else if (fire) begin
            tx_cnt_q <= tx_cnt_q + 8'h01;
            if (st_q != S_CRCLO && st_q != S_CRCHI) begin
                tx_crc_q <= rrh_crc_step(tx_crc_q, push_data);
            end
        end
    end

    // -----------------------------------------------------------------
    // two entry output buffer
    // -----------------------------------------------------------------
    logic [8:0] buf_q [2];
    logic       wr_ptr_q;
    logic       rd_ptr_q;
    logic [1:0] fill_q;
    logic       pop;

    assign push_ready = (fill_q != 2'd2);
    assign tx_valid_o = (fill_q != 2'd0);
    assign pop        = tx_valid_o && tx_ready_i;
    assign tx_data_o  = buf_q[rd_ptr_q][7:0];
    assign tx_last_o  = buf_q[rd_ptr_q][8];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_q[0] <= 9'h000;
            buf_q[1] <= 9'h000;
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            fill_q   <= 2'd0;
        end else begin
            if (fire) begin
                buf_q[wr_ptr_q] <= {push_last, push_data};
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (pop) rd_ptr_q <= ~rd_ptr_q;
            if (fire && !pop) fill_q <= fill_q + 2'd1;
            else if (!fire && pop) fill_q <= fill_q - 2'd1;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    property p_len_limit;
        @(posedge clk_i) disable iff (!rstn_i)
        fire |=> (tx_cnt_q <= FRAME_MAX);
    endproperty
    a_len_limit: assert property (p_len_limit)
        else $error("response longer than limit");

    property p_echo_addr;
        @(posedge clk_i) disable iff (!rstn_i)
        start |=> (st_q == S_ADDR) && (push_data == $past(node_addr_i));
    endproperty
    a_echo_addr: assert property (p_echo_addr)
        else $error("reply does not open with node address");

    property p_echo_func;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_ADDR && fire) |=> (push_data == func_q) && func_q != 8'h00;
    endproperty
    a_echo_func: assert property (p_echo_func)
        else $error("function code not echoed");

    property p_own_node;
        @(posedge clk_i) disable iff (!rstn_i)
        start |-> (q_byte_q[0] != ADDR_BCAST) && (q_byte_q[0] <= NODE_MAX);
    endproperty
    a_own_node: assert property (p_own_node)
        else $error("reply to foreign or broadcast address");

    property p_pad_zero;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_COIL && left_q < GROUP_BITS) |->
            ((push_data >> left_q[2:0]) == 8'h00);
    endproperty
    a_pad_zero: assert property (p_pad_zero)
        else $error("unused bits of last byte not zero");

    property p_first_bit;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_COIL && left_q != 16'h0000) |->
            (push_data[0] == coil_bit(cur_addr_q));
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first bit not in bit 0");

    property p_reg_order;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_REGHI && fire) |=>
            (st_q == S_REGLO) && (push_data == $past(reg_val_q[7:0]));
    endproperty
    a_reg_order: assert property (p_reg_order)
        else $error("register low byte out of order");

    property p_ascend;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_REGLO && fire) |=>
            (cur_addr_q == 16'($past(cur_addr_q) + 16'h0001));
    endproperty
    a_ascend: assert property (p_ascend)
        else $error("registers not ascending");

    property p_crc_order;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_CRCLO && fire) |=>
            (push_data == tx_crc_q[15:8]) && push_last;
    endproperty
    a_crc_order: assert property (p_crc_order)
        else $error("crc bytes out of order");

    property p_count;
        @(posedge clk_i) disable iff (!rstn_i)
        (st_q == S_CNT) |-> (push_data == bc_q) && (bc_q != 8'h00);
    endproperty
    a_count: assert property (p_count)
        else $error("byte count field wrong");
endmodule : rrh_frame_handler
`default_nettype wire

// *** bench/rrh_link_master.sv ***
// link master model: sends queries and collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module rrh_link_master (
    input  wire logic       clk_i,
    input  wire logic       stall_i,
    output logic            rx_valid_o,
    output logic [7:0]      rx_data_o,
    output logic            rx_end_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o
);
    logic [7:0] got[$];
    logic       last_seen = 1'b0;
    logic       tog = 1'b0;

    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        rx_end_o   = 1'b0;
    end

    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    task automatic query(input logic [7:0] a, f, input logic [15:0] s, n,
                         input logic bad);
        logic [7:0]  q[$];
        logic [15:0] c;
        q = {a, f, s[15:8], s[7:0], n[15:8], n[7:0]};
        c = crc16(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        got.delete();
        last_seen = 1'b0;
        foreach (q[i]) begin
            @(negedge clk_i);
            rx_valid_o = 1'b1;
            rx_data_o  = q[i];
        end
        @(negedge clk_i);
        rx_valid_o = 1'b0;
        rx_data_o  = ~rx_data_o;
        rx_end_o   = 1'b1;
        @(negedge clk_i);
        rx_end_o   = 1'b0;
    endtask : query

    // stalling sink accepts every other cycle
    always @(negedge clk_i) tog <= ~tog;
    assign tx_ready_o = stall_i ? tog : 1'b1;

    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_data_i);
            if (tx_last_i) last_seen = 1'b1;
        end
    end
endmodule : rrh_link_master
`default_nettype wire

// *** bench/tb.sv ***
// self-checking testbench for the read frame handler
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rrh_pkg::*;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [7:0]  node_addr_i = 8'h01;
    logic [7:0]  status_bits_i = 8'h04;
    logic [7:0]  cmd_bits_i = 8'hb5;
    logic        reg_ack_i = 1'b0;
    logic [15:0] reg_data_i = 16'h0000;
    logic        stall = 1'b0;
    logic        rx_valid, rx_end, tx_ready, reg_req_o, tx_valid, tx_last;
    logic        busy_o;
    logic [7:0]  rx_data, tx_data;
    logic [15:0] reg_addr_o;
    int          fails = 0;
    int          check_count = 0;
    int          lag = 0;
    int          wait_n = 0;

    always #12.5 clk_i = ~clk_i;

    rrh_frame_handler dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
        .node_addr_i(node_addr_i), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .rx_end_i(rx_end),
        .status_bits_i(status_bits_i), .cmd_bits_i(cmd_bits_i),
        .reg_req_o(reg_req_o), .reg_addr_o(reg_addr_o),
        .reg_ack_i(reg_ack_i), .reg_data_i(reg_data_i),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last),
        .tx_ready_i(tx_ready), .busy_o(busy_o));

    rrh_link_master m_u (.clk_i(clk_i), .stall_i(stall),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_end_o(rx_end),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last),
        .tx_ready_o(tx_ready));

    // register source: answers after lag cycles, data scrambles address
    always @(negedge clk_i) begin
        reg_ack_i  <= 1'b0;
        reg_data_i <= ~reg_data_i;
        if (reg_req_o && !reg_ack_i) begin
            if (wait_n >= lag) begin
                reg_ack_i  <= 1'b1;
                reg_data_i <= reg_addr_o ^ 16'h5a3c;
                wait_n     <= 0;
            end else begin
                wait_n <= wait_n + 1;
            end
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    function automatic logic coil(input int a);
        if (a < 8) return status_bits_i[a];
        if (a >= 100 && a < 108) return cmd_bits_i[a - 100];
        return 1'b0;
    endfunction : coil

    // -----------------------------------------------------------------
    // one query, expected reply built here, compared byte by byte
    // -----------------------------------------------------------------
    task automatic run(input logic [7:0] a, f, input logic [15:0] s, n,
                       input logic bad, input logic ok);
        logic [7:0]  e[$];
        logic [7:0]  b;
        logic [15:0] c;
        logic [15:0] v;
        int          k;
        m_u.query(a, f, s, n, bad);
        @(negedge clk_i);
        cmp({15'h0000, busy_o}, {15'h0000, ok});
        if (ok) begin
            e = {a, f};
            if (f == FN_READ_BITS) begin
                e.push_back(8'((n + 16'd7) / 16'd8));
                for (int i = 0; i < n; i += 8) begin
                    b = 8'h00;
                    for (int j = 0; j < 8 && i + j < n; j++) begin
                        b[j] = coil(s + i + j);
                    end
                    e.push_back(b);
                end
            end else begin
                e.push_back(8'(n * 16'd2));
                for (int i = 0; i < n; i++) begin
                    v = (s + 16'(i)) ^ 16'h5a3c;
                    e.push_back(v[15:8]);
                    e.push_back(v[7:0]);
                end
            end
            c = m_u.crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
            k = 0;
            while (!m_u.last_seen && k < 3000) begin
                @(negedge clk_i);
                k++;
            end
            if (k == 3000) begin
                fails++;
                report_and_stop();
            end
        end else begin
            repeat (40) @(negedge clk_i);
        end
        @(negedge clk_i);
        cmp(16'(m_u.got.size()), 16'(e.size()));
        foreach (e[i]) begin
            if (i < m_u.got.size()) begin
                cmp({8'h00, m_u.got[i]}, {8'h00, e[i]});
            end
        end
    endtask : run

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic coil_reads();
        run(8'h01, FN_READ_BITS, 16'd1, 16'd2, 1'b0, 1'b1);
        cmp({8'h00, m_u.got[3]}, 16'h0002);
        cmp({m_u.got[5], m_u.got[4]}, 16'h49d0);
        run(8'h01, FN_READ_BITS, 16'd99, 16'd9, 1'b0, 1'b1);
        run(8'h01, FN_READ_BITS, 16'd0, 16'd984, 1'b0, 1'b1);
    endtask : coil_reads

    task automatic reg_reads();
        stall = 1'b1;
        lag   = 3;
        run(8'h01, FN_READ_REGS, 16'd5000, 16'd2, 1'b0, 1'b1);
        run(8'h01, FN_READ_REGS, 16'd0, 16'd61, 1'b0, 1'b1);
        stall = 1'b0;
        lag   = 0;
        node_addr_i = 8'hf7;
        run(8'hf7, FN_READ_REGS, 16'd100, 16'd3, 1'b0, 1'b1);
        node_addr_i = 8'h01;
    endtask : reg_reads

    task automatic refusals();
        run(8'h01, FN_READ_BITS, 16'd0, 16'd985, 1'b0, 1'b0);
        run(8'h01, FN_READ_REGS, 16'd0, 16'd62, 1'b0, 1'b0);
        run(8'h00, FN_READ_BITS, 16'd0, 16'd2, 1'b0, 1'b0);
        run(8'h02, FN_READ_REGS, 16'd0, 16'd1, 1'b0, 1'b0);
        run(8'h01, FN_READ_REGS, 16'd0, 16'd1, 1'b1, 1'b0);
        run(8'h01, FN_READ_BITS, 16'd0, 16'd0, 1'b0, 1'b0);
        run(8'h01, 8'h05, 16'd0, 16'd1, 1'b0, 1'b0);
        node_addr_i = 8'h00;
        run(8'h00, FN_READ_REGS, 16'd0, 16'd1, 1'b0, 1'b0);
        node_addr_i = 8'h01;
    endtask : refusals

    // reset in the middle of a long reply: outputs drop, next query works
    task automatic reset_cut();
        m_u.query(8'h01, FN_READ_BITS, 16'd0, 16'd984, 1'b0);
        repeat (20) @(negedge clk_i);
        cmp({15'h0000, busy_o}, 16'h0001);
        rstn_i = 1'b0;
        @(negedge clk_i);
        cmp({14'h0000, busy_o, tx_valid}, 16'h0000);
        cmp({6'h00, reg_req_o, tx_last, tx_data}, 16'h0000);
        rstn_i = 1'b1;
        run(8'h01, FN_READ_BITS, 16'd1, 16'd2, 1'b0, 1'b1);
    endtask : reset_cut

    initial begin
        repeat (6) @(negedge clk_i);
        rstn_i = 1'b1;
        coil_reads();
        reg_reads();
        refusals();
        reset_cut();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
